// >>> rtl/ttr_map.svh
// Purpose: constants of the three-tone ringer sequencer
// Assumes: resonator ticks arrive at 455 kHz
// Notes:   divisors round down, period limits from window edges
`ifndef TTR_MAP_SVH
`define TTR_MAP_SVH
`define TTR_REF_HZ      455000
`define TTR_TONE_LO_HZ  800
`define TTR_TONE_MID_HZ 1067
`define TTR_TONE_HI_HZ  1333
`define TTR_DIV_LO      (`TTR_REF_HZ / `TTR_TONE_LO_HZ)
`define TTR_DIV_MID     (`TTR_REF_HZ / `TTR_TONE_MID_HZ)
`define TTR_DIV_HI      (`TTR_REF_HZ / `TTR_TONE_HI_HZ)
`define TTR_RING_MAX_HZ 54
`define TTR_RING_NAR_HZ 23
`define TTR_RING_WID_HZ 12
`define TTR_PER_MIN     (`TTR_REF_HZ / `TTR_RING_MAX_HZ)
`define TTR_PER_MAX_NAR (`TTR_REF_HZ / `TTR_RING_NAR_HZ)
`define TTR_PER_MAX_WID (`TTR_REF_HZ / `TTR_RING_WID_HZ)
`define TTR_PRESC       192
`define TTR_OFS_CTRL    12'h000
`define TTR_OFS_STATUS  12'h004
`define TTR_OFS_PERIOD  12'h008
`define TTR_CTRL_RESET  32'h0000_0001
`define TTR_CTRL_EN     0
`endif

// >>> rtl/ttr_pkg.sv
// Purpose: types of the three-tone ringer sequencer
// Assumes: nothing
// Notes:   shared by ttr_tone_gen, ttr_top and the bench
package ttr_pkg;
    typedef enum logic [1:0] {WIN_NARROW, WIN_WIDE, WIN_DC} ttr_win_t;
    typedef enum logic [1:0] {TONE_LO, TONE_MID, TONE_HI} ttr_tone_t;
    typedef enum logic {RS_IDLE, RS_RING} ttr_ring_st_t;
    typedef struct packed {
        logic p;
        logic n;
    } ttr_drive_t;
    typedef struct packed {
        logic [25:0] zero;
        ttr_win_t    win;
        ttr_tone_t   tone;
        logic        freq_ok;
        logic        ringing;
    } ttr_status_t;
endpackage : ttr_pkg

// >>> rtl/ttr_period_meas.sv
// Purpose: measures the ringing period in resonator ticks
// Assumes: ring_rise is a one-cycle pulse per ringing period
// Notes:   first edge after silence never qualifies
`timescale 1ns/10ps
`default_nettype none
module ttr_period_meas #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         nrst,
    // events
    input  wire logic         ref_tick,
    input  wire logic         ring_rise,
    // limits
    input  wire logic [W-1:0] min_lim,
    input  wire logic [W-1:0] max_lim,
    // results
    output logic      [W-1:0] period,
    output logic              freq_ok
);
    logic [W-1:0] cnt_reg;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            cnt_reg <= '0;
        end else if (ring_rise) begin
            // a tick on the edge cycle belongs to the new period
            cnt_reg <= W'(ref_tick);
        end else if (ref_tick && cnt_reg != '1) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // compare period count with window limits
    always_ff @(posedge clock) begin
        if (!nrst) begin
            period  <= '0;
            freq_ok <= 1'b0;
        end else if (ring_rise) begin
            period  <= cnt_reg;
            freq_ok <= cnt_reg >= min_lim && cnt_reg <= max_lim; // RL14
        end else if (cnt_reg > max_lim) begin
            freq_ok <= 1'b0; // RL14
        end
    end
endmodule : ttr_period_meas
`default_nettype wire

// >>> rtl/ttr_tone_gen.sv
// Purpose: divides resonator ticks into one tone of three
// Assumes: ref_tick is a one-cycle pulse at 455 kHz
// Notes:   short mode gives quarter-period pulses per side
`timescale 1ns/10ps
`default_nettype none
`include "ttr_map.svh"
module ttr_tone_gen
    import ttr_pkg::*;
#(
    parameter int W = 10
) (
    // clock and reset
    input  wire logic      clock,
    input  wire logic      nrst,
    // control
    input  wire logic      ref_tick,
    input  wire logic      run,
    input  wire ttr_pkg::ttr_tone_t tone,
    input  wire logic      short_mode,
    // bridge drive
    output ttr_pkg::ttr_drive_t drive
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] div;
    logic [W-1:0] half;
    logic [W-1:0] quart;

    function automatic logic [W-1:0] tone_div(input ttr_tone_t t);
        unique case (t)
            TONE_LO:  tone_div = W'(`TTR_DIV_LO);
            TONE_MID: tone_div = W'(`TTR_DIV_MID);
            TONE_HI:  tone_div = W'(`TTR_DIV_HI);
            default:  tone_div = W'(`TTR_DIV_LO);
        endcase
    endfunction : tone_div

    assign div   = tone_div(tone); // RL5
    assign half  = div >> 1;
    assign quart = div >> 2;

    always_ff @(posedge clock) begin
        if (!nrst || !run) begin
            cnt_reg <= '0;
        end else if (ref_tick) begin
            cnt_reg <= (cnt_reg >= div - 1'b1) ? '0 : cnt_reg + 1'b1; // RL4
        end
    end

    // antiphase bridge pair, idle both low
    always_ff @(posedge clock) begin
        if (!nrst || !run) begin
            drive <= '0;
        end else if (!short_mode) begin
            drive.p <= cnt_reg < half; // RL8
            drive.n <= !(cnt_reg < half); // RL10
        end else begin
            drive.p <= cnt_reg < quart; // RL9
            drive.n <= cnt_reg >= half && cnt_reg < half + quart; // RL10
        end
    end
endmodule : ttr_tone_gen
`default_nettype wire

// >>> rtl/ttr_top.sv
// Purpose: three-tone ringer sequencer with APB status and control
// Assumes: pins are asynchronous to clock, resonator below clock/2
// Notes:   all pin inputs pass two flops before use
// Functional notes
// [RL1] Pin open: ringing valid only between 23 Hz and 54 Hz.
// [RL2] Pin grounded: ringing valid between 12 Hz and 54 Hz.
// [RL3] Pin tied to supply: no frequency check, DC operation.
// [RL4] Tones and ring timing both come from the 455 kHz resonator.
// [RL5] Tones are 800, 1067 and 1333 Hz divided from the resonator.
// [RL6] Tone steps come from the sequence oscillator divided by 192.
// [RL7] Each ringing burst starts on the lowest tone.
// [RL8] Shape pin grounded gives a 1:1 square wave.
// [RL9] Shape pin open gives shortened pulses.
// [RL10] The two tone outputs drive the transducer in antiphase.
// [RL11] Recognised ringing pulls on/off low and drops the dummy load.
// [RL12] Without ringing on/off is high and the dummy load is on.
// [RL13] Tones step low, middle, high, one per tick, then wrap.
// [RL14] Frequency is judged by counting ticks over one ring period.
`timescale 1ns/10ps
`default_nettype none
`include "ttr_map.svh"
module ttr_top
    import ttr_pkg::*;
#(
    parameter int        PW         = 16,
    parameter logic [15:0] PER_MIN  = 16'(`TTR_PER_MIN),
    parameter logic [15:0] PER_NAR  = 16'(`TTR_PER_MAX_NAR),
    parameter logic [15:0] PER_WID  = 16'(`TTR_PER_MAX_WID),
    parameter int        PRESC      = `TTR_PRESC
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        nrst,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // pins
    input  wire logic        ref_clk_in,
    input  wire logic        seq_osc_in,
    input  wire logic        ring_in,
    input  wire logic        amp_ok,
    input  wire logic        win_gnd,
    input  wire logic        win_sup,
    input  wire logic        shape_gnd,
    // outputs
    output ttr_pkg::ttr_drive_t tone_drive,
    output logic             onoff_high,
    output logic             dummy_load_en
);
    localparam int NS = 7;

    logic [NS-1:0] pin_raw;
    logic [NS-1:0] sync1_reg;
    logic [NS-1:0] sync2_reg;
    logic [2:0]    prev_reg;
    logic          ref_tick;
    logic          seq_rise;
    logic          ring_rise;
    ttr_win_t      win;
    logic [PW-1:0] max_lim;
    logic [PW-1:0] period;
    logic          freq_ok;
    logic          ring_ok;
    logic [7:0]    presc_reg;
    logic          step;
    ttr_ring_st_t  st_reg;
    ttr_ring_st_t  st_next;
    ttr_tone_t     tone_reg;
    logic [31:0]   ctrl_reg;
    ttr_status_t   status;
    logic          apb_acc;

    assign pin_raw = {shape_gnd, win_sup, win_gnd, amp_ok,
                      ring_in, seq_osc_in, ref_clk_in};

    // two-flop synchronisers, one per pin
    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_sync
            always_ff @(posedge clock) begin
                if (!nrst) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= pin_raw[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    // edge detect reads only the second stage
    always_ff @(posedge clock) begin
        if (!nrst) begin
            prev_reg <= '0;
        end else begin
            prev_reg <= sync2_reg[2:0];
        end
    end

    assign ref_tick  = sync2_reg[0] && !prev_reg[0]; // RL4
    assign seq_rise  = sync2_reg[1] && !prev_reg[1];
    assign ring_rise = sync2_reg[2] && !prev_reg[2];

    // three-state window pin seen as two sense bits
    function automatic ttr_win_t win_decode(input logic gnd,
                                            input logic sup);
        if (sup) begin
            win_decode = WIN_DC; // RL3
        end else if (gnd) begin
            win_decode = WIN_WIDE; // RL2
        end else begin
            win_decode = WIN_NARROW; // RL1
        end
    endfunction : win_decode

    assign win     = win_decode(sync2_reg[4], sync2_reg[5]);
    assign max_lim = (win == WIN_WIDE) ? PER_WID : PER_NAR; // RL1 RL2

    ttr_period_meas #(.W(PW)) u_meas (
        .clock     (clock),
        .nrst      (nrst),
        .ref_tick  (ref_tick),
        .ring_rise (ring_rise),
        .min_lim   (PER_MIN),
        .max_lim   (max_lim),
        .period    (period),
        .freq_ok   (freq_ok)
    );

    // dc mode bypasses the frequency window entirely
    assign ring_ok = ctrl_reg[`TTR_CTRL_EN] && sync2_reg[3]
                     && (win == WIN_DC || freq_ok); // RL3 RL11

    always_comb begin
        st_next = ring_ok ? RS_RING : RS_IDLE;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st_reg <= RS_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // prescaler restarts with each burst so the first step is whole
    always_ff @(posedge clock) begin
        if (!nrst || st_reg == RS_IDLE) begin
            presc_reg <= '0;
        end else if (seq_rise) begin
            presc_reg <= (presc_reg == 8'(PRESC - 1)) ? '0
                         : presc_reg + 1'b1; // RL6
        end
    end

    assign step = seq_rise && presc_reg == 8'(PRESC - 1); // RL6

    always_ff @(posedge clock) begin
        if (!nrst || st_reg == RS_IDLE) begin
            tone_reg <= TONE_LO; // RL7
        end else if (step) begin
            unique case (tone_reg)
                TONE_LO:  tone_reg <= TONE_MID; // RL13
                TONE_MID: tone_reg <= TONE_HI; // RL13
                TONE_HI:  tone_reg <= TONE_LO; // RL13
                default:  tone_reg <= TONE_LO;
            endcase
        end
    end

    ttr_tone_gen u_tone (
        .clock      (clock),
        .nrst       (nrst),
        .ref_tick   (ref_tick),
        .run        (st_reg == RS_RING),
        .tone       (tone_reg),
        .short_mode (!sync2_reg[6]),
        .drive      (tone_drive)
    );

    // on/off pin low and load off only while ringing
    always_ff @(posedge clock) begin
        if (!nrst) begin
            onoff_high    <= 1'b1;
            dummy_load_en <= 1'b1;
        end else begin
            onoff_high    <= st_reg != RS_RING; // RL11 RL12
            dummy_load_en <= st_reg != RS_RING; // RL11 RL12
        end
    end

    // apb: pready one cycle into the access phase
    assign apb_acc = psel && penable && !pready;

    always_comb begin
        status         = '0;
        status.ringing = st_reg == RS_RING;
        status.freq_ok = freq_ok;
        status.tone    = tone_reg;
        status.win     = win;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ctrl_reg <= `TTR_CTRL_RESET;
        end else if (psel && penable && pready && pwrite
                     && paddr == `TTR_OFS_CTRL) begin
            ctrl_reg <= {31'h0, pwdata[`TTR_CTRL_EN]};
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= apb_acc;
            prdata  <= '0;
            pslverr <= 1'b0;
            if (apb_acc) begin
                unique case (paddr)
                    `TTR_OFS_CTRL:   prdata <= pwrite ? '0 : ctrl_reg;
                    `TTR_OFS_STATUS: prdata <= pwrite ? '0 : status;
                    `TTR_OFS_PERIOD: prdata <= pwrite ? '0
                                               : 32'(period);
                    default:         pslverr <= 1'b1;
                endcase
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_onoff_follow: assert property ( // RL11
        $rose(st_reg == RS_RING) |=> !onoff_high && !dummy_load_en)
        else $error("on/off not low one cycle after ringing starts");

    a_onoff_idle: assert property ( // RL12
        st_reg == RS_IDLE ##1 st_reg == RS_IDLE |-> onoff_high
                                                   && dummy_load_en)
        else $error("on/off not high while idle");

    a_start_low: assert property ( // RL7
        $rose(st_reg == RS_RING) |-> tone_reg == TONE_LO)
        else $error("burst did not start on lowest tone");

    a_step_order: assert property ( // RL13
        st_reg == RS_RING && step && tone_reg == TONE_LO
        ##1 st_reg == RS_RING |-> tone_reg == TONE_MID)
        else $error("tone did not step low to middle");

    a_step_wrap: assert property ( // RL13
        st_reg == RS_RING && step && tone_reg == TONE_HI
        ##1 st_reg == RS_RING |-> tone_reg == TONE_LO)
        else $error("tone did not wrap to lowest");

    a_tone_hold: assert property ( // RL6
        st_reg == RS_RING && !step ##1 st_reg == RS_RING
        |-> $stable(tone_reg))
        else $error("tone moved without a prescaled tick");

    a_dc_bypass: assert property ( // RL3
        win == WIN_DC && ctrl_reg[0] && sync2_reg[3] |=> st_reg == RS_RING)
        else $error("dc mode did not ring");

    a_win_gate: assert property ( // RL1
        win != WIN_DC && !freq_ok |=> st_reg == RS_IDLE)
        else $error("rang without frequency qualification");

    a_bridge_1to1: assert property ( // RL8
        st_reg == RS_RING && sync2_reg[6] |=> tone_drive.p != tone_drive.n)
        else $error("1:1 bridge outputs not complementary");

    a_bridge_short: assert property ( // RL9
        !sync2_reg[6] |-> !(tone_drive.p && tone_drive.n))
        else $error("short pulses overlap on both outputs");

    a_apb_answer: assert property (
        psel && penable && !pready |=> pready)
        else $error("apb access not answered in one cycle");

    a_step_mid_hi: assert property ( // RL13
        st_reg == RS_RING && step && tone_reg == TONE_MID
        ##1 st_reg == RS_RING |-> tone_reg == TONE_HI)
        else $error("tone did not step middle to high");

    a_load_ring: assert property ( // RL11
        st_reg == RS_RING |=> !onoff_high && !dummy_load_en)
        else $error("dummy load on while ringing");

    a_idle_quiet: assert property ( // RL12
        st_reg == RS_IDLE |=> tone_drive == '0)
        else $error("tone outputs driven while idle");

    a_need_amp: assert property ( // RL11
        !sync2_reg[3] |=> st_reg == RS_IDLE)
        else $error("rang without amplitude recognition");

    a_need_enable: assert property (
        !ctrl_reg[0] |=> st_reg == RS_IDLE)
        else $error("rang while disabled");

    a_presc_idle: assert property ( // RL6
        st_reg == RS_IDLE |=> presc_reg == '0)
        else $error("prescaler not cleared while idle");

    // limits are those of the edge cycle, result lands one cycle later
    a_freq_judge: assert property ( // RL14
        ring_rise |=> freq_ok == (period >= PER_MIN
                                  && period <= $past(max_lim)))
        else $error("period judged against wrong limits");

    a_pready_pulse: assert property (
        pready |=> !pready)
        else $error("pready held for more than one cycle");

    a_err_with_ready: assert property (
        pslverr |-> pready)
        else $error("slave error without pready");

    a_rdata_idle: assert property (
        !pready |-> prdata == '0)
        else $error("read data outside the answer cycle");

    c_ring_burst: cover property ($rose(st_reg == RS_RING));
    c_full_cycle: cover property (step && tone_reg == TONE_HI);
    c_dc_ring: cover property (win == WIN_DC && st_reg == RS_RING);
    c_bad_addr: cover property (pslverr);
    c_freq_pass: cover property (ring_rise ##1 freq_ok);
endmodule : ttr_top
`default_nettype wire

// >>> verif/ttr_line_model.sv
// Purpose: far side of the ringer: resonator, sequence oscillator, line
// Assumes: driven from the bench clock, 40 MHz
// Notes:   resonator sped up to clock/8 so tone periods stay short
`timescale 1ns/10ps
`default_nettype none
module ttr_line_model (
    // clock
    input  wire logic        clock,
    // controls from the bench
    input  wire logic        seq_en,
    input  wire logic [15:0] ring_half,
    // pins toward the block
    output logic             ref_clk_in,
    output logic             seq_osc_in,
    output logic             ring_in
);
    logic [1:0]  ref_cnt  = 2'h0;
    logic [3:0]  seq_cnt  = 4'h0;
    logic [15:0] ring_cnt = 16'h0;

    initial begin
        ref_clk_in = 1'b0;
        seq_osc_in = 1'b0;
        ring_in    = 1'b0;
    end

    // free-running resonator, one tick every 8 clocks
    always @(posedge clock) begin
        ref_cnt <= ref_cnt + 2'h1;
        if (ref_cnt == 2'h3)
            ref_clk_in <= ~ref_clk_in;
    end

    // oscillator stands low while not wanted
    always @(posedge clock) begin
        if (!seq_en) begin
            seq_cnt    <= 4'h0;
            seq_osc_in <= 1'b0;
        end else begin
            seq_cnt <= seq_cnt + 4'h1;
            if (seq_cnt == 4'hf)
                seq_osc_in <= ~seq_osc_in;
        end
    end

    // zero half period means a silent line
    always @(posedge clock) begin
        if (ring_half == 16'h0) begin
            ring_cnt <= 16'h0;
            ring_in  <= 1'b0;
        end else if (ring_cnt >= ring_half - 16'h1) begin
            ring_cnt <= 16'h0;
            ring_in  <= ~ring_in;
        end else begin
            ring_cnt <= ring_cnt + 16'h1;
        end
    end
endmodule : ttr_line_model
`default_nettype wire

// >>> verif/three_tone_ringer_sequencer_test.sv
// Purpose: self-checking bench of the three-tone ringer sequencer
// Assumes: resonator tick every 8 clocks, prescaler shrunk to 4
// Notes:   period limits shrunk to 8, 20 and 40 ticks
`timescale 1ns/10ps
`default_nettype none
`include "ttr_map.svh"
module three_tone_ringer_sequencer_test;
    import ttr_pkg::*;
    localparam int PRESC = 4;
    localparam int REFC  = 8;
    localparam int DIV [3] = '{`TTR_DIV_LO, `TTR_DIV_MID, `TTR_DIV_HI};
    logic        clock = 1'b0;
    logic        nrst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        ref_clk_in, seq_osc_in, ring_in, amp_ok;
    logic        win_gnd, win_sup, shape_gnd, onoff_high, dummy_load_en;
    logic        seq_en;
    logic [15:0] ring_half;
    ttr_drive_t  tone_drive;
    int          failures = 0;
    int          checks   = 0;

    always #12.5 clock = ~clock;

    ttr_top #(.PER_MIN(16'h0008), .PER_NAR(16'h0014), .PER_WID(16'h0028),
        .PRESC(PRESC)) u_dut (
        .clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ref_clk_in(ref_clk_in),
        .seq_osc_in(seq_osc_in), .ring_in(ring_in), .amp_ok(amp_ok),
        .win_gnd(win_gnd), .win_sup(win_sup), .shape_gnd(shape_gnd),
        .tone_drive(tone_drive), .onoff_high(onoff_high),
        .dummy_load_en(dummy_load_en));

    ttr_line_model u_line (
        .clock(clock), .seq_en(seq_en), .ring_half(ring_half),
        .ref_clk_in(ref_clk_in), .seq_osc_in(seq_osc_in), .ring_in(ring_in));

    task automatic close_out;
        if (failures == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic er);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_level(input logic v, input int lim);
        int n;
        n = 0;
        while (onoff_high !== v && n < lim) begin
            @(posedge clock);
            n++;
        end
    endtask : wait_level

    task automatic wait_p(input logic v);
        int n;
        n = 0;
        while (tone_drive.p !== v && n < 6000) begin
            @(posedge clock);
            n++;
        end
    endtask : wait_p

    // skips one rise so a tone change never lands inside the count
    task automatic measure(output int per, output int hi, output int bad);
        logic prev;
        per = 0;
        hi = 0;
        bad = 0;
        wait_p(1'b0);
        wait_p(1'b1);
        wait_p(1'b0);
        wait_p(1'b1);
        prev = 1'b1;
        while (!(prev === 1'b0 && tone_drive.p === 1'b1) && per < 6000) begin
            if (tone_drive.p === 1'b1) hi++;
            if (shape_gnd === 1'b1 && tone_drive.n !== ~tone_drive.p) bad++;
            if (tone_drive.n === 1'b1 && tone_drive.p === 1'b1) bad++;
            prev = tone_drive.p;
            @(posedge clock);
            per++;
        end
    endtask : measure

    task automatic step_seq;
        seq_en <= 1'b1;
        repeat (PRESC * 32) @(posedge clock);
        seq_en <= 1'b0;
        repeat (8) @(posedge clock);
    endtask : step_seq

    task automatic t_reset;
        logic [31:0] rd;
        logic        er;
        chk("onoff_high", 32'h1, onoff_high);
        chk("dummy_load_en", 32'h1, dummy_load_en);
        chk("tone_drive", 32'h0, tone_drive);
        apb(1'b0, 12'h000, 32'h0, rd, er);
        chk("ctrl", 32'h1, rd);
        apb(1'b1, 12'h004, 32'hffff_ffff, rd, er);
        apb(1'b0, 12'h004, 32'h0, rd, er);
        chk("status", 32'h20, rd & 32'hffff_fffd);
        apb(1'b0, 12'h00c, 32'h0, rd, er);
        chk("unmapped_err", 32'h1, er);
        chk("unmapped_data", 32'h0, rd);
    endtask : t_reset

    task automatic t_dc;
        logic [31:0] rd;
        logic        er;
        int          per, hi, bad;
        amp_ok <= 1'b1;
        wait_level(1'b0, 200);
        chk("onoff_high", 32'h0, onoff_high);
        chk("dummy_load_en", 32'h0, dummy_load_en);
        apb(1'b0, 12'h004, 32'h0, rd, er);
        chk("tone", 32'h0, rd[3:2]);
        measure(per, hi, bad);
        chk("period_lo", DIV[0] * REFC, per);
        chk("high_lo", DIV[0] / 2 * REFC, hi);
        chk("antiphase", 32'h0, bad);
        for (int i = 1; i < 4; i++) begin
            step_seq;
            apb(1'b0, 12'h004, 32'h0, rd, er);
            chk("tone", i % 3, rd[3:2]);
            measure(per, hi, bad);
            chk("period", DIV[i % 3] * REFC, per);
        end
    endtask : t_dc

    task automatic t_short;
        int per, hi, bad;
        shape_gnd <= 1'b0;
        measure(per, hi, bad);
        chk("short_high", DIV[0] / 4 * REFC, hi);
        chk("short_overlap", 32'h0, bad);
        shape_gnd <= 1'b1;
    endtask : t_short

    task automatic t_stop;
        logic [31:0] rd;
        logic        er;
        step_seq;
        amp_ok <= 1'b0;
        wait_level(1'b1, 200);
        chk("onoff_high", 32'h1, onoff_high);
        chk("dummy_load_en", 32'h1, dummy_load_en);
        repeat (4) @(posedge clock);
        chk("tone_idle", 32'h0, tone_drive);
        amp_ok <= 1'b1;
        wait_level(1'b0, 200);
        apb(1'b0, 12'h004, 32'h0, rd, er);
        chk("tone_restart", 32'h0, rd[3:2]);
        apb(1'b1, 12'h000, 32'h0, rd, er);
        wait_level(1'b1, 200);
        chk("onoff_high", 32'h1, onoff_high);
        apb(1'b1, 12'h000, 32'h1, rd, er);
        wait_level(1'b0, 200);
        chk("onoff_high", 32'h0, onoff_high);
    endtask : t_stop

    task automatic t_window;
        logic [31:0] rd;
        logic        er;
        win_sup <= 1'b0;
        wait_level(1'b1, 400);
        chk("onoff_silent", 32'h1, onoff_high);
        ring_half <= 16'h003c;
        wait_level(1'b0, 2000);
        chk("onoff_15", 32'h0, onoff_high);
        apb(1'b0, 12'h008, 32'h0, rd, er);
        chk("period_reg", 32'hf, rd);
        ring_half <= 16'h0078;
        wait_level(1'b1, 2000);
        chk("onoff_30_nar", 32'h1, onoff_high);
        win_gnd <= 1'b1;
        wait_level(1'b0, 2000);
        chk("onoff_30_wid", 32'h0, onoff_high);
        apb(1'b0, 12'h004, 32'h0, rd, er);
        chk("window", 32'h1, rd[5:4]);
        ring_half <= 16'h0014;
        wait_level(1'b1, 2000);
        chk("onoff_5", 32'h1, onoff_high);
    endtask : t_window

    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        amp_ok = 1'b0;
        win_gnd = 1'b0;
        win_sup = 1'b1;
        shape_gnd = 1'b1;
        seq_en = 1'b0;
        ring_half = 16'h0;
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        t_reset;
        t_dc;
        t_short;
        t_stop;
        t_window;
        close_out;
    end

    // whole run stays near 60k cycles
    initial begin
        repeat (95000) @(posedge clock);
        failures++;
        close_out;
    end
endmodule : three_tone_ringer_sequencer_test
`default_nettype wire
